// *** shp_host_port.sv ***
`timescale 1ns/100ps
module shp_host_port (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Command port
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire shp_pkg::shp_cmd_s cmd,
	// Read data stream
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [shp_pkg::DATA_W-1:0] rd_data,
	// Status
	output logic busy,
	// Device pins
	output shp_pkg::shp_pins_s pins,
	input wire logic [shp_pkg::DATA_W-1:0] dev_data_in
);
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WAIT,
		ST_ACTIVE,
		ST_NEXT,
		ST_RELEASE
	} shp_state_e;

	shp_state_e state, next_state;
	shp_pkg::shp_cmd_s cur, next_cur;
	shp_pkg::shp_prev_e prev, next_prev;
	shp_pkg::shp_pins_s next_pins;
	logic [7:0] cnt, next_cnt;
	logic [7:0] gap_cnt, next_gap_cnt;
	logic [shp_pkg::LEN_W-1:0] left, next_left;
	logic next_cmd_ready, next_busy;
	logic push, next_push;
	logic [shp_pkg::DATA_W-1:0] push_data, next_push_data;
	logic [shp_pkg::DATA_W-1:0] din_meta, din_sync;
	logic fifo_in_ready;
	logic [7:0] gap_need;
	logic is_read;

	// ==========================================================
	// Input synchroniser for the device data bus
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			din_meta <= 16'h0000;
			din_sync <= 16'h0000;
		end else begin
			din_meta <= dev_data_in;
			din_sync <= din_meta;
		end
	end

	// ==========================================================
	// Spacing needed before the pending access
	always_comb begin
		is_read = cur.op != shp_pkg::OP_WRITE;
		gap_need = shp_pkg::GAP_MIN;
		if (is_read) begin
			unique case (prev)
				shp_pkg::PK_WRITE: gap_need = shp_pkg::GAP_WRITE;
				shp_pkg::PK_WRITE_SLOW: gap_need = shp_pkg::GAP_SLOW;
				shp_pkg::PK_FIFO_READ: begin
					if (!cur.fifo_sel && (cur.addr == shp_pkg::ADDR_RX_INFO
						|| cur.addr == shp_pkg::ADDR_TX_INFO)) begin
						gap_need = shp_pkg::GAP_WRITE;
					end
				end
				shp_pkg::PK_DROP_READ: begin
					if (!cur.fifo_sel && cur.addr == shp_pkg::ADDR_RX_DROP) begin
						gap_need = shp_pkg::GAP_SLOW;
					end
				end
				shp_pkg::PK_NONE, shp_pkg::PK_OTHER_READ: gap_need = shp_pkg::GAP_MIN;
			endcase
		end
	end

	// ==========================================================
	// Cycle sequencer
	always_comb begin
		next_state = state;
		next_cur = cur;
		next_prev = prev;
		next_pins = pins;
		next_cnt = cnt;
		next_left = left;
		next_push = 1'b0;
		next_push_data = push_data;
		next_gap_cnt = (gap_cnt == 8'hff) ? gap_cnt : gap_cnt + 8'h01;
		unique case (state)
			ST_IDLE: begin
				if (cmd_valid && cmd_ready) begin
					next_cur = cmd;
					unique case (cmd.op)
						shp_pkg::OP_READ, shp_pkg::OP_WRITE: begin
							next_left = 16'h0001;
						end
						shp_pkg::OP_BURST: begin
							next_cur.fifo_sel = 1'b0;
							if (cmd.len > shp_pkg::REG_BURST_MAX) begin
								next_left = shp_pkg::REG_BURST_MAX;
							end else begin
								next_left = (cmd.len == 16'h0000) ? 16'h0001 : cmd.len;
							end
						end
						shp_pkg::OP_FIFO_BURST: begin
							next_cur.fifo_sel = 1'b1;
							next_left = (cmd.len == 16'h0000) ? 16'h0001 : cmd.len;
						end
					endcase
					next_state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (gap_cnt >= gap_need && (!is_read || (!push && fifo_in_ready))) begin
					// Only the strobe of this access falls; address and select are set alongside
					next_pins.select_low = 1'b0;
					next_pins.read_strobe_low = !is_read;
					next_pins.write_strobe_low = is_read;
					next_pins.fifo_sel = cur.fifo_sel;
					next_pins.addr = cur.addr;
					next_pins.data_out = cur.wdata;
					next_pins.data_oe = !is_read;
					next_cnt = 8'h00;
					next_state = ST_ACTIVE;
				end
			end
			ST_ACTIVE: begin
				next_cnt = cnt + 8'h01;
				if (cur.op == shp_pkg::OP_READ || cur.op == shp_pkg::OP_WRITE) begin
					// Capture late in the low phase, well past data valid
					if (cnt == shp_pkg::CAP_SINGLE) begin
						next_push = is_read;
						next_push_data = din_sync;
						next_state = ST_RELEASE;
						next_pins.select_low = 1'b1;
						next_pins.read_strobe_low = 1'b1;
						next_pins.write_strobe_low = 1'b1;
					end
				end else if (cnt == shp_pkg::CAP_SLOT) begin
					next_push = 1'b1;
					next_push_data = din_sync;
					next_left = left - 16'h0001;
					if (left == 16'h0001) begin
						next_state = ST_RELEASE;
						next_pins.select_low = 1'b1;
						next_pins.read_strobe_low = 1'b1;
					end else begin
						next_state = ST_NEXT;
					end
				end
			end
			ST_NEXT: begin
				// Strobes stay low; the address steps once buffer room is sure
				if (!push && fifo_in_ready) begin
					if (cur.op == shp_pkg::OP_FIFO_BURST) begin
						next_pins.addr[1:0] = pins.addr[1:0] + 2'h1;
					end else begin
						next_pins.addr = pins.addr + 7'h01;
					end
					next_cnt = 8'h00;
					next_state = ST_ACTIVE;
				end
			end
			ST_RELEASE: begin
				// Write data held one cycle past the strobe release
				next_pins.data_oe = 1'b0;
				next_gap_cnt = 8'h01;
				next_state = ST_IDLE;
				if (!is_read) begin
					next_prev = (cur.addr == shp_pkg::ADDR_PM_CTRL
						|| cur.addr == shp_pkg::ADDR_FREE_RUN)
						? shp_pkg::PK_WRITE_SLOW : shp_pkg::PK_WRITE;
				end else if (cur.fifo_sel || cur.addr == shp_pkg::ADDR_RX_STATUS
					|| cur.addr == shp_pkg::ADDR_TX_STATUS) begin
					next_prev = shp_pkg::PK_FIFO_READ;
				end else if (cur.addr == shp_pkg::ADDR_RX_DROP) begin
					next_prev = shp_pkg::PK_DROP_READ;
				end else begin
					next_prev = shp_pkg::PK_OTHER_READ;
				end
			end
		endcase
		if (state == ST_RELEASE) begin
			next_gap_cnt = 8'h00;
		end
		next_cmd_ready = next_state == ST_IDLE;
		next_busy = next_state != ST_IDLE;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state <= ST_IDLE;
			cur <= '0;
			prev <= shp_pkg::PK_NONE;
			pins <= '{select_low: 1'b1, read_strobe_low: 1'b1, write_strobe_low: 1'b1,
				fifo_sel: 1'b0, addr: 7'h00, data_out: 16'h0000, data_oe: 1'b0};
			cnt <= 8'h00;
			gap_cnt <= 8'hff;
			left <= 16'h0000;
			push <= 1'b0;
			push_data <= 16'h0000;
			cmd_ready <= 1'b0;
			busy <= 1'b0;
		end else begin
			state <= next_state;
			cur <= next_cur;
			prev <= next_prev;
			pins <= next_pins;
			cnt <= next_cnt;
			gap_cnt <= next_gap_cnt;
			left <= next_left;
			push <= next_push;
			push_data <= next_push_data;
			cmd_ready <= next_cmd_ready;
			busy <= next_busy;
		end
	end

	// ==========================================================
	// Read data buffer
	shp_fifo #(
		.WIDTH(shp_pkg::DATA_W),
		.DEPTH(shp_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk(core_clk),
		.rst(rst),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.in_data(push_data),
		.out_valid(rd_valid),
		.out_ready(rd_ready),
		.out_data(rd_data)
	);

	// ==========================================================
	// Checks on the pin sequence and on buffer pushes
	logic act, act_q;
	logic [7:0] since_start, idle_len, since_addr, words;

	assign act = !pins.select_low && (!pins.read_strobe_low || !pins.write_strobe_low);

	// Helper counters that only the checks read
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			act_q <= 1'b0;
			since_start <= 8'hff;
			idle_len <= 8'hff;
			since_addr <= 8'h00;
			words <= 8'h00;
		end else begin
			act_q <= act;
			since_start <= (act && !act_q) ? 8'h01 : (since_start == 8'hff ? 8'hff : since_start + 8'h01);
			idle_len <= act ? 8'h00 : (idle_len == 8'hff ? 8'hff : idle_len + 8'h01);
			since_addr <= (pins.addr != next_pins.addr) ? 8'h01
				: (since_addr == 8'hff ? 8'hff : since_addr + 8'h01);
			words <= !act ? 8'h00 : ((act && !act_q) ? 8'h01
				: (pins.addr != $past(pins.addr) ? words + 8'h01 : words));
		end
	end

	no_rd_wr_a: assert property (@(posedge core_clk) disable iff (rst)
		!(!pins.read_strobe_low && !pins.write_strobe_low))
		else $error("read and write strobes low together");

	cycle_min_a: assert property (@(posedge core_clk) disable iff (rst)
		(act && !act_q) |-> since_start >= 8'(shp_pkg::TCYCLE_CYC))
		else $error("cycle start spacing below minimum");

	idle_min_a: assert property (@(posedge core_clk) disable iff (rst)
		(act && !act_q) |-> idle_len >= 8'(shp_pkg::TCSH_CYC))
		else $error("strobe release time below minimum");

	burst_cap_a: assert property (@(posedge core_clk) disable iff (rst)
		(act && cur.op == shp_pkg::OP_BURST) |-> words <= 8'h10)
		else $error("register burst longer than sixteen words");

	addr_hold_a: assert property (@(posedge core_clk) disable iff (rst)
		(act && act_q && pins.addr != $past(pins.addr)) |-> $past(since_addr) >= 8'(shp_pkg::SLOT_CYC))
		else $error("burst address held too briefly");

	fsel_stable_a: assert property (@(posedge core_clk) disable iff (rst)
		(act && act_q) |-> ($stable(pins.fifo_sel)
			&& pins.fifo_sel == (cur.op == shp_pkg::OP_FIFO_BURST) || cur.op == shp_pkg::OP_READ))
		else $error("fifo select moved during a cycle");

	fifo_upper_a: assert property (@(posedge core_clk) disable iff (rst)
		(act && act_q && cur.op == shp_pkg::OP_FIFO_BURST) |-> $stable(pins.addr[6:2]))
		else $error("upper address moved in fifo burst");

	rd_float_a: assert property (@(posedge core_clk) disable iff (rst)
		!pins.read_strobe_low |-> !pins.data_oe)
		else $error("host drives data during a read");

	wr_setup_a: assert property (@(posedge core_clk) disable iff (rst)
		(!pins.write_strobe_low ##1 pins.write_strobe_low)
			|-> pins.data_oe && $stable(pins.data_out) && $past(since_start) >= 8'(shp_pkg::TDSU_CYC))
		else $error("write data not held through release");

	war_gap_a: assert property (@(posedge core_clk) disable iff (rst)
		(act && !act_q && !pins.read_strobe_low && prev == shp_pkg::PK_WRITE_SLOW)
			|-> idle_len >= 8'(shp_pkg::WAIT_SLOW_CYC))
		else $error("read too soon after slow write");

	push_room_a: assert property (@(posedge core_clk) disable iff (rst)
		push |-> fifo_in_ready ##1 !push)
		else $error("push without room or twice in a row");

	single_cv: cover property (@(posedge core_clk) disable iff (rst)
		cur.op == shp_pkg::OP_READ && push);
	write_cv: cover property (@(posedge core_clk) disable iff (rst)
		!pins.write_strobe_low ##1 pins.write_strobe_low);
	burst_cv: cover property (@(posedge core_clk) disable iff (rst)
		act && cur.op == shp_pkg::OP_BURST && words == 8'h10);
	stall_cv: cover property (@(posedge core_clk) disable iff (rst)
		state == ST_NEXT && !fifo_in_ready);
endmodule

// *** shp_pkg.sv ***
// ==========================================================
// Shared constants and types of the host PIO port controller
package shp_pkg;

	// ==========================================================
	// Clock and pin timing
	localparam int CLK_PERIOD_NS = 5;
	localparam int TCYCLE_NS = 165;
	localparam int TCSL_NS = 32;
	localparam int TCSH_NS = 13;
	localparam int TCSDV_NS = 30;
	localparam int TADV_NS = 40;
	localparam int TDSU_NS = 7;
	localparam int WAIT_SLOW_NS = 330;
	// Least times round up to whole cycles
	localparam int TCYCLE_CYC = (TCYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TCSL_CYC = (TCSL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TCSH_CYC = (TCSH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TCSDV_CYC = (TCSDV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TADV_CYC = (TADV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TDSU_CYC = (TDSU_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WAIT_SLOW_CYC = (WAIT_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Strobe low time of a single cycle; release phase fills the rest
	localparam int ASSERT_CYC = TCYCLE_CYC - TCSH_CYC;
	// One burst word per address slot
	localparam int SLOT_CYC = TCYCLE_CYC;
	localparam int SYNC_STAGES = 2;
	localparam logic [7:0] CAP_SINGLE = 8'(ASSERT_CYC - 1);
	localparam logic [7:0] CAP_SLOT = 8'(SLOT_CYC - 1);
	localparam logic [7:0] GAP_MIN = 8'(TCSH_CYC);
	localparam logic [7:0] GAP_WRITE = 8'(TCYCLE_CYC);
	localparam logic [7:0] GAP_SLOW = 8'(WAIT_SLOW_CYC);

	// ==========================================================
	// Bus and buffer sizes
	localparam int DATA_W = 16;
	localparam int ADDR_W = 7;
	localparam int LEN_W = 16;
	localparam int FIFO_DEPTH = 32;
	localparam logic [LEN_W-1:0] REG_BURST_MAX = 16'h0010;

	// ==========================================================
	// Word addresses (A[7:1]) of registers with access-spacing needs
	localparam logic [ADDR_W-1:0] ADDR_RX_STATUS = 7'h20;
	localparam logic [ADDR_W-1:0] ADDR_TX_STATUS = 7'h24;
	localparam logic [ADDR_W-1:0] ADDR_RX_INFO = 7'h3e;
	localparam logic [ADDR_W-1:0] ADDR_TX_INFO = 7'h40;
	localparam logic [ADDR_W-1:0] ADDR_PM_CTRL = 7'h42;
	localparam logic [ADDR_W-1:0] ADDR_FREE_RUN = 7'h4e;
	localparam logic [ADDR_W-1:0] ADDR_RX_DROP = 7'h50;

	// ==========================================================
	// Commands, history and carriers
	typedef enum logic [1:0] {
		OP_READ,
		OP_WRITE,
		OP_BURST,
		OP_FIFO_BURST
	} shp_op_e;

	typedef enum logic [2:0] {
		PK_NONE,
		PK_WRITE,
		PK_WRITE_SLOW,
		PK_FIFO_READ,
		PK_DROP_READ,
		PK_OTHER_READ
	} shp_prev_e;

	typedef struct packed {
		shp_op_e op;
		logic fifo_sel;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [LEN_W-1:0] len;
	} shp_cmd_s;

	typedef struct packed {
		logic select_low;
		logic read_strobe_low;
		logic write_strobe_low;
		logic fifo_sel;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data_out;
		logic data_oe;
	} shp_pins_s;

endpackage

// *** shp_fifo.sv ***
`timescale 1ns/100ps
// ==========================================================
// Read data buffer with valid/ready on both sides
module shp_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr, next_wr_ptr;
	logic [PW-1:0] rd_ptr, next_rd_ptr;
	logic [PW:0] count, next_count;
	logic push, pop;

	// Pointer, count and flag update
	always_comb begin
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
		next_count = count + (PW+1)'(push) - (PW+1)'(pop);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready <= 1'b0;
			out_valid <= 1'b0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
			in_ready <= next_count != FULL_CNT;
			out_valid <= next_count != '0;
		end
	end

	// Storage array
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	assign out_data = mem[rd_ptr];
endmodule

// *** shp_dev_model.sv ***
`timescale 1ns/100ps
// ==========================================================
// Device behind the host port: registers, receive FIFO, host timing watch
module shp_dev_model (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Host pins and the data bus level they see
	input wire shp_pkg::shp_pins_s pins,
	output logic [15:0] bus_level,
	// Host timing faults seen so far
	output logic [15:0] viol
);
	localparam int CYC = shp_pkg::TCYCLE_CYC;
	localparam int SLOW = shp_pkg::WAIT_SLOW_CYC;
	logic [15:0] regs [128];
	logic [15:0] fifo_cnt, last_bus, drive_val, p_wdata;
	logic [6:0] p_addr;
	logic rd_act, wr_act, p_rd, p_wr, p_fsel, info, status;
	int low_cnt, high_cnt, cyc_cnt, slot_cnt, dstab, words, bad;
	shp_pkg::shp_prev_e last_kind;

	// ==========================================================
	// Cycle decode and driven data
	assign rd_act = !pins.select_low && !pins.read_strobe_low;
	assign wr_act = !pins.select_low && !pins.write_strobe_low;
	assign info = pins.addr inside {shp_pkg::ADDR_RX_INFO, shp_pkg::ADDR_TX_INFO};
	assign status = p_addr inside {shp_pkg::ADDR_RX_STATUS, shp_pkg::ADDR_TX_STATUS};
	// FIFO mode keeps only the low address bits
	assign drive_val = pins.fifo_sel ? {fifo_cnt[13:0], pins.addr[1:0]}
		: regs[pins.addr];
	// Garbage until settled; released bus shows the inverse of its last level
	always_comb begin
		if (rd_act && pins.data_oe) bus_level = 'x;
		else if (rd_act) bus_level = (slot_cnt >= 4 && pins.addr == p_addr)
			? drive_val : ~drive_val;
		else if (pins.data_oe) bus_level = pins.data_out;
		else bus_level = ~last_bus;
	end

	// ==========================================================
	// Register file, FIFO pops and host timing watch
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 128; i++) regs[i] <= 16'hc300 + 16'(i);
			{p_rd, p_wr, p_fsel} <= 3'h0;
			p_addr <= 7'h00;
			p_wdata <= 16'h0000;
			{fifo_cnt, last_bus, viol} <= 48'h0;
			{low_cnt, slot_cnt, dstab, words} <= 128'h0;
			cyc_cnt <= 1000;
			high_cnt <= 1000;
			last_kind <= shp_pkg::PK_NONE;
		end else begin
			bad = 0;
			p_rd <= rd_act;
			p_wr <= wr_act;
			p_addr <= pins.addr;
			p_fsel <= pins.fifo_sel;
			p_wdata <= pins.data_out;
			dstab <= (pins.data_out == p_wdata) ? dstab + 1 : 1;
			cyc_cnt <= cyc_cnt + 1;
			if (rd_act || pins.data_oe) last_bus <= bus_level;
			if (!rd_act) slot_cnt <= 0;
			if (rd_act || wr_act) begin
				low_cnt <= low_cnt + 1;
				high_cnt <= 0;
			end else high_cnt <= high_cnt + 1;
			// Start of a cycle: release gap and access spacing
			if ((rd_act || wr_act) && !(p_rd || p_wr)) begin
				bad += int'(high_cnt < shp_pkg::TCSH_CYC);
				bad += int'(cyc_cnt < CYC);
				if (rd_act) begin
					bad += int'(last_kind == shp_pkg::PK_WRITE && high_cnt < CYC);
					bad += int'(last_kind == shp_pkg::PK_WRITE_SLOW && high_cnt < SLOW);
					bad += int'(info && last_kind == shp_pkg::PK_FIFO_READ && high_cnt < CYC);
					bad += int'(!pins.fifo_sel && pins.addr == shp_pkg::ADDR_RX_DROP &&
						last_kind == shp_pkg::PK_DROP_READ && high_cnt < SLOW);
				end
				cyc_cnt <= 1;
				low_cnt <= 1;
				slot_cnt <= 1;
				words <= 0;
			end
			// Inside a read: address slots and burst word count
			if (rd_act && p_rd) begin
				bad += int'(pins.fifo_sel != p_fsel);
				if (pins.addr != p_addr) begin
					bad += int'(slot_cnt < CYC);
					bad += int'(!p_fsel && words >= 15);
					if (p_fsel) fifo_cnt <= fifo_cnt + 16'h0001;
					words <= words + 1;
					slot_cnt <= 1;
				end else slot_cnt <= slot_cnt + 1;
			end
			// End of a read: one pop per completed word
			if (p_rd && !rd_act) begin
				bad += int'(low_cnt < shp_pkg::TCSL_CYC);
				if (p_fsel) fifo_cnt <= fifo_cnt + 16'h0001;
				if (p_fsel || status) last_kind <= shp_pkg::PK_FIFO_READ;
				else if (p_addr == shp_pkg::ADDR_RX_DROP) last_kind <= shp_pkg::PK_DROP_READ;
				else last_kind <= shp_pkg::PK_OTHER_READ;
			end
			// End of a write: capture data held before release
			if (p_wr && !wr_act) begin
				regs[p_addr] <= p_wdata;
				bad += int'(low_cnt < shp_pkg::TCSL_CYC || dstab < shp_pkg::TDSU_CYC);
				if (p_addr inside {shp_pkg::ADDR_PM_CTRL, shp_pkg::ADDR_FREE_RUN})
					last_kind <= shp_pkg::PK_WRITE_SLOW;
				else last_kind <= shp_pkg::PK_WRITE;
			end
			bad += int'(rd_act && pins.data_oe);
			viol <= viol + 16'(bad);
		end
	end
endmodule

// *** shp_host_port_tb_top.sv ***
`timescale 1ns/100ps
// ==========================================================
// Self-checking bench of the host PIO port controller
module shp_host_port_tb_top;
	logic core_clk, rst, cmd_valid, cmd_ready, rd_valid, rd_ready, busy;
	// Asks the next single read to go to the receive FIFO directly
	logic fsel_req;
	shp_pkg::shp_cmd_s cmd;
	shp_pkg::shp_pins_s pins;
	logic [15:0] rd_data, bus_level, viol;
	int error_cnt, compares;
	logic [15:0] exp_q [$];

	// ==========================================================
	// Controller, device model and clock
	shp_host_port shp_host_port_inst (.core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd(cmd), .rd_valid(rd_valid), .rd_ready(rd_ready),
		.rd_data(rd_data), .busy(busy), .pins(pins), .dev_data_in(bus_level));
	shp_dev_model shp_dev_model_inst (.core_clk(core_clk), .rst(rst), .pins(pins),
		.bus_level(bus_level), .viol(viol));
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	// ==========================================================
	// Report, compare and bus tasks
	task automatic close_out();
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic give_up();
		error_cnt++;
		$display("timeout at %0t", $time);
		close_out();
	endtask

	// Offer one command at a falling edge, hold until taken
	task automatic send(input shp_pkg::shp_op_e op, input logic [6:0] addr,
		input logic [15:0] wdata, input logic [15:0] len);
		int i;
		for (i = 0; i < 5000 && cmd_ready !== 1'b1; i++) @(negedge core_clk);
		if (i == 5000) give_up();
		cmd = '{op: op, fifo_sel: (op == shp_pkg::OP_FIFO_BURST) || fsel_req, addr: addr,
			wdata: wdata, len: len};
		cmd_valid = 1'b1;
		@(negedge core_clk);
		cmd_valid = 1'b0;
	endtask

	// Take n words from the read stream against the expected queue
	task automatic recv(input int n);
		int got, i;
		got = 0;
		rd_ready = 1'b1;
		for (i = 0; i < 30000 && got < n; i++) begin
			if (rd_valid === 1'b1) begin
				check_word(rd_data, exp_q.pop_front());
				got++;
			end
			@(negedge core_clk);
		end
		rd_ready = 1'b0;
		if (got < n) give_up();
	endtask

	task automatic wait_idle();
		int i;
		for (i = 0; i < 5000 && !(busy === 1'b0 && cmd_ready === 1'b1); i++) @(negedge core_clk);
		if (i == 5000) give_up();
	endtask

	// ==========================================================
	// Scenarios
	task automatic s_single_reads();
		logic [6:0] a [3] = '{7'h00, 7'h01, 7'h7f};
		foreach (a[i]) begin
			send(shp_pkg::OP_READ, a[i], 16'h0000, 16'h0001);
			exp_q.push_back(16'hc300 + 16'(a[i]));
		end
		recv(3);
	endtask

	task automatic s_write_read();
		send(shp_pkg::OP_WRITE, 7'h10, 16'h5a3c, 16'h0001);
		send(shp_pkg::OP_READ, 7'h10, 16'h0000, 16'h0001);
		send(shp_pkg::OP_WRITE, shp_pkg::ADDR_PM_CTRL, 16'h0123, 16'h0001);
		send(shp_pkg::OP_READ, shp_pkg::ADDR_PM_CTRL, 16'h0000, 16'h0001);
		exp_q = '{16'h5a3c, 16'h0123};
		recv(2);
	endtask

	task automatic s_reg_burst();
		send(shp_pkg::OP_BURST, 7'h30, 16'h0000, 16'h0010);
		for (int k = 0; k < 16; k++) exp_q.push_back(16'hc330 + 16'(k));
		recv(16);
		send(shp_pkg::OP_BURST, 7'h60, 16'h0000, 16'h0014);
		for (int k = 0; k < 16; k++) exp_q.push_back(16'hc360 + 16'(k));
		recv(16);
		wait_idle();
		check_word({15'h0000, rd_valid}, 16'h0000);
	endtask

	task automatic s_fifo_stall();
		send(shp_pkg::OP_FIFO_BURST, 7'h7d, 16'h0000, 16'h0028);
		repeat (1500) @(negedge core_clk);
		check_word({15'h0000, busy}, 16'h0001);
		for (int k = 0; k < 40; k++) exp_q.push_back({k[13:0], 2'(k + 1)});
		recv(40);
		wait_idle();
		// Single direct FIFO read: forty words popped, low address bits 2'b10
		fsel_req = 1'b1;
		send(shp_pkg::OP_READ, 7'h7a, 16'h0000, 16'h0001);
		fsel_req = 1'b0;
		send(shp_pkg::OP_READ, shp_pkg::ADDR_RX_INFO, 16'h0000, 16'h0001);
		send(shp_pkg::OP_READ, shp_pkg::ADDR_RX_DROP, 16'h0000, 16'h0001);
		send(shp_pkg::OP_READ, shp_pkg::ADDR_RX_DROP, 16'h0000, 16'h0001);
		exp_q = '{16'h00a2, 16'hc33e, 16'hc350, 16'hc350};
		recv(4);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		rst = 1'b1;
		cmd_valid = 1'b0;
		rd_ready = 1'b0;
		fsel_req = 1'b0;
		cmd = '0;
		error_cnt = 0;
		compares = 0;
		repeat (12) @(posedge core_clk);
		@(negedge core_clk);
		check_word({13'h0000, pins.select_low, pins.read_strobe_low, pins.write_strobe_low,
			pins.data_oe}, 16'h000e);
		rst = 1'b0;
		s_single_reads();
		s_write_read();
		s_reg_burst();
		s_fifo_stall();
		wait_idle();
		check_word(viol, 16'h0000);
		close_out();
	end
endmodule
